// *** inc/rbi_pkg.sv ***
// Package: offsets, fields, reset values and timing for the reset, boot and identity block
`default_nettype none
package rbi_pkg;
	// Register indices as printed; byte address is four times the index
	localparam int unsigned  REG_IDX_SOFT_RESET = 32'h0000_0000;
	localparam int unsigned  REG_IDX_REVISION   = 32'h0000_0001;
	localparam int unsigned  REG_IDX_RAW_STS5   = 32'h0000_0D23;
	localparam int unsigned  REG_IDX_IRQ_MASK5  = 32'h0000_0E00;
	localparam int unsigned  REG_IDX_SLEEP_CTRL = 32'h0000_0E01;
	localparam int unsigned  REG_IDX_AON_SCRATCH = 32'h0000_0E02;
	localparam int unsigned  REG_IDX_RETAIN_STS = 32'h0000_0E03;
	localparam logic [11:0]  ADDR_SOFT_RESET  = 12'h000;
	localparam logic [11:0]  ADDR_REVISION    = 12'h004;
	localparam logic [15:0]  ADDR_RAW_STS5_HI = 16'h348C;
	localparam logic [15:0]  ADDR_IRQ_MASK5   = 16'h3800;
	localparam logic [15:0]  ADDR_SLEEP_CTRL  = 16'h3804;
	localparam logic [15:0]  ADDR_AON_SCRATCH = 16'h3808;
	localparam logic [15:0]  ADDR_RETAIN_STS  = 16'h380C;
	// Field positions
	localparam int unsigned  BOOT_DONE_BIT  = 8;
	localparam int unsigned  SLEEP_REQ_BIT  = 0;
	// Reset values
	localparam logic [15:0]  IRQ_MASK_RST   = 16'h0000;
	localparam logic [15:0]  AON_SCRATCH_RST = 16'h0000;
	// Boot sequence length in cycles of the 50 MHz clock
	localparam int unsigned  BOOT_CYCLES    = 64;
	localparam int unsigned  CLK_HZ         = 50_000_000;
	// Minimum wait after wake-up, in microseconds, and derived cycles
	localparam int unsigned  WAKE_WAIT_US   = 1500;
	localparam int unsigned  WAKE_WAIT_CYC  = (WAKE_WAIT_US * (CLK_HZ / 1_000_000));
	localparam int unsigned  CNT_W          = 17;
	// Pad control codes
	localparam logic [1:0]   PULL_NONE = 2'b00;
	localparam logic [1:0]   PULL_DOWN = 2'b01;
	localparam logic [1:0]   PULL_UP   = 2'b10;
	typedef enum logic [1:0] {
		RBI_RST_NONE,
		RBI_RST_SOFT,
		RBI_RST_WAKE
	} rbi_rst_kind_e;
endpackage
`default_nettype wire

// *** hdl/rbi_boot_seq.sv ***
// Boot sequencer: runs a fixed count after each reset and raises a done flag
`default_nettype none
module rbi_boot_seq
	import rbi_pkg::*;
#(
	parameter int unsigned BOOT_LEN = BOOT_CYCLES
) (
	input  wire logic  ref_clk_i,
	input  wire logic  rst_b_i,
	input  wire logic  restart_i,
	output logic       busy_o,
	output logic       done_o
);
	typedef struct packed {
		logic [15:0] cnt;
		logic        done;
	} rbi_boot_s;
	rbi_boot_s st_reg;
	rbi_boot_s st_next;

	always_comb begin
		st_next = st_reg;
		if (restart_i) begin
			st_next.cnt  = '0;
			st_next.done = 1'b0;
		end else if (!st_reg.done) begin
			if (st_reg.cnt == 16'(BOOT_LEN - 1)) begin
				st_next.done = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign done_o = st_reg.done;
	assign busy_o = !st_reg.done;

	a_boot_len_exact: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(st_reg.done) |-> $past(st_reg.cnt) == 16'(BOOT_LEN - 1))
		else $error("boot done at wrong count");
	a_boot_restart_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		restart_i |=> !done_o)
		else $error("boot done not cleared by restart");
endmodule // rbi_boot_seq
`default_nettype wire

// *** hdl/rbi_wake_timer.sv ***
// Wake timer: counts the minimum quiet time after a wake-up event
`default_nettype none
module rbi_wake_timer
	import rbi_pkg::*;
#(
	parameter int unsigned WAIT_LEN = WAKE_WAIT_CYC
) (
	input  wire logic  ref_clk_i,
	input  wire logic  rst_b_i,
	input  wire logic  start_i,
	output logic       busy_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} rbi_wt_s;
	rbi_wt_s st_reg;
	rbi_wt_s st_next;

	always_comb begin
		st_next = st_reg;
		if (start_i) begin
			st_next.cnt = CNT_W'(WAIT_LEN);
		end else if (st_reg.cnt != '0) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign busy_o = (st_reg.cnt != '0);
endmodule // rbi_wake_timer
`default_nettype wire

// *** hdl/rbi_top.sv ***
// Reset, boot and identity control with APB registers, interrupt and pad defaults
//
// Decided for this implementation: the APB interface to the registers.
`default_nettype none
module rbi_top
	import rbi_pkg::*;
#(
	parameter logic [15:0] DEVICE_ID  = 16'h0A5A,	// Value is arbitrary
	parameter logic [7:0]  REVISION   = 8'h01,	// Value is arbitrary
	parameter int unsigned BOOT_LEN   = BOOT_CYCLES,
	parameter int unsigned WAKE_LEN   = WAKE_WAIT_CYC
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [15:0]  paddr_i,
	input  wire logic [31:0]  pwdata_i,
	input  wire logic [3:0]   pstrb_i,
	output logic              pready_o,
	output logic [31:0]       prdata_o,
	output logic              pslverr_o,
	input  wire logic         wake_pin_i,
	output logic              irq_b_o,
	output logic              core_rst_b_o,
	output logic              dsp_mem_clear_o,
	output logic              wseq_mem_keep_o,
	output logic              sleep_o,
	output logic              write_blocked_o,
	output logic              mic_digital_en_o,
	output logic [1:0]        gpio_pull_o,
	output logic [1:0]        regulator_enable_pin_pull_o,
	output logic [1:0]        test_port_pull_o,
	output logic [1:0]        hw_reset_pin_pull_o
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic        wake_s1;
		logic        wake_s2;
		logic        wake_d;
		logic        sleep;
		logic        sts_boot;
		logic        sts_wake;
		logic [15:0] mask;
		logic        mic_dig;
		logic        restart;
		logic        wake_start;
		logic        dsp_clr;
		logic [15:0] aon_scratch;
		logic [31:0] rdata;
		logic        slverr;
		logic        boot_seen;
	} rbi_top_s;
	rbi_top_s st_reg;
	rbi_top_s st_next;

	logic boot_busy;
	logic boot_done;
	logic wake_busy;
	logic wr_acc;
	logic rd_acc;
	logic in_bank_lo;

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	rbi_boot_seq #(
		.BOOT_LEN (BOOT_LEN)
	) u_boot (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.restart_i (st_reg.restart),
		.busy_o    (boot_busy),
		.done_o    (boot_done)
	);

	rbi_wake_timer #(
		.WAIT_LEN (WAKE_LEN)
	) u_wake (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.start_i   (st_reg.wake_start),
		.busy_o    (wake_busy)
	);

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign wr_acc     = psel_i && penable_i && pwrite_i;
	assign rd_acc     = psel_i && penable_i && !pwrite_i;
	assign in_bank_lo = (paddr_i[15:12] == 4'h0);

	always_comb begin
		st_next            = st_reg;
		st_next.wake_s1    = wake_pin_i;
		st_next.wake_s2    = st_reg.wake_s1;
		st_next.wake_d     = st_reg.wake_s2;
		st_next.restart    = 1'b0;
		st_next.wake_start = 1'b0;
		st_next.dsp_clr    = 1'b0;

		// Boot flag event: sticky, clear by restart wins over set
		if (st_reg.restart) begin
			st_next.boot_seen = 1'b0;
			st_next.sts_boot  = 1'b0;
		end else if (boot_done && !st_reg.boot_seen) begin
			st_next.boot_seen = 1'b1;
		end

		// Write-one-to-clear of status, applied before sets
		if (wr_acc && paddr_i == ADDR_RAW_STS5_HI && pstrb_i[1]) begin
			if (pwdata_i[BOOT_DONE_BIT]) begin
				st_next.sts_boot = 1'b0;
			end
			if (pwdata_i[0] && pstrb_i[0]) begin
				st_next.sts_wake = 1'b0;
			end
		end
		if (boot_done && !st_reg.boot_seen && !st_reg.restart) begin
			st_next.sts_boot = 1'b1;
		end

		// Sleep entry clears processor memory, wake behaves like soft reset
		if (wr_acc && paddr_i == ADDR_SLEEP_CTRL && pstrb_i[0]
				&& pwdata_i[SLEEP_REQ_BIT] && !st_reg.sleep) begin
			st_next.sleep   = 1'b1;
			st_next.dsp_clr = 1'b1;
		end
		if (st_reg.sleep && st_reg.wake_s2 && !st_reg.wake_d) begin
			st_next.sleep      = 1'b0;
			st_next.restart    = 1'b1;
			st_next.wake_start = 1'b1;
			st_next.sts_wake   = 1'b1;
		end

		// Soft reset: any write to address zero
		if (wr_acc && paddr_i == 16'(ADDR_SOFT_RESET)) begin
			st_next.restart = 1'b1;
		end

		// Normal register writes; blocked only while booting, not in wake wait
		if (wr_acc && !boot_busy) begin
			case (paddr_i)
				ADDR_IRQ_MASK5: begin
					if (pstrb_i[0]) st_next.mask[7:0] = pwdata_i[7:0];
					if (pstrb_i[1]) st_next.mask[15:8] = pwdata_i[15:8];
				end
				ADDR_AON_SCRATCH: begin
					if (pstrb_i[0]) st_next.aon_scratch[7:0] = pwdata_i[7:0];
					if (pstrb_i[1]) st_next.aon_scratch[15:8] = pwdata_i[15:8];
				end
				ADDR_RETAIN_STS: begin
					if (pstrb_i[0]) st_next.mic_dig = pwdata_i[0];
				end
				default: begin
				end
			endcase
		end

		// Registers outside the always-on domain return to defaults
		if (st_reg.restart) begin
			st_next.mask    = IRQ_MASK_RST;
			st_next.mic_dig = 1'b0;
		end

		// Read data
		st_next.slverr = 1'b0;
		if (rd_acc) begin
			st_next.rdata = 32'h0000_0000;
			if (paddr_i == 16'(ADDR_SOFT_RESET)) begin
				st_next.rdata[15:0] = DEVICE_ID;
			end else if (paddr_i == 16'(ADDR_REVISION)) begin
				st_next.rdata[7:0] = REVISION;
			end else if (paddr_i == ADDR_RAW_STS5_HI) begin
				st_next.rdata[BOOT_DONE_BIT] = st_reg.boot_seen;
				st_next.rdata[0] = st_reg.sts_wake;
			end else if (paddr_i == ADDR_IRQ_MASK5) begin
				st_next.rdata[15:0] = st_reg.mask;
			end else if (paddr_i == ADDR_SLEEP_CTRL) begin
				st_next.rdata[0] = st_reg.sleep;
				st_next.rdata[1] = wake_busy;
				st_next.rdata[2] = boot_busy;
			end else if (paddr_i == ADDR_AON_SCRATCH) begin
				st_next.rdata[15:0] = st_reg.aon_scratch;
			end else if (paddr_i == ADDR_RETAIN_STS) begin
				st_next.rdata[0] = st_reg.mic_dig;
			end else begin
				st_next.slverr = 1'b1;
			end
		end
		if (wr_acc && !in_bank_lo && paddr_i != ADDR_RAW_STS5_HI
				&& paddr_i != ADDR_IRQ_MASK5 && paddr_i != ADDR_SLEEP_CTRL
				&& paddr_i != ADDR_AON_SCRATCH && paddr_i != ADDR_RETAIN_STS) begin
			st_next.slverr = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg             <= '0;
			st_reg.mask        <= IRQ_MASK_RST;
			st_reg.aon_scratch <= AON_SCRATCH_RST;
			st_reg.restart     <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// APB answers in the access cycle; slverr flagged combinationally
	assign pready_o  = 1'b1;
	assign prdata_o  = rd_acc ? st_next.rdata : 32'h0000_0000;
	assign pslverr_o = psel_i && penable_i && st_next.slverr;

	// Default mask routes boot done: mask bit set means suppressed
	assign irq_b_o = !((st_reg.sts_boot && !st_reg.mask[BOOT_DONE_BIT])
		|| (st_reg.sts_wake && !st_reg.mask[0]));

	assign core_rst_b_o     = !st_reg.restart && !st_reg.sleep;
	assign dsp_mem_clear_o  = st_reg.dsp_clr;
	assign wseq_mem_keep_o  = 1'b1;
	assign sleep_o          = st_reg.sleep;
	assign write_blocked_o  = boot_busy || wake_busy;
	assign mic_digital_en_o = st_reg.mic_dig;

	assign gpio_pull_o                 = PULL_DOWN;
	assign regulator_enable_pin_pull_o = PULL_DOWN;
	assign test_port_pull_o            = PULL_DOWN;
	assign hw_reset_pin_pull_o         = PULL_UP;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_soft_rst_write: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wr_acc && paddr_i == 16'(ADDR_SOFT_RESET)) |=> st_reg.restart ##1 !boot_done)
		else $error("soft reset write did not restart boot");
	a_boot_flag_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(st_reg.boot_seen && !st_reg.restart) |=> st_reg.boot_seen)
		else $error("boot flag dropped without reset");
	a_boot_flag_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |=> !st_reg.boot_seen)
		else $error("boot flag not cleared by reset");
	a_irq_on_boot: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		($rose(st_reg.sts_boot) && !st_reg.mask[BOOT_DONE_BIT]) |-> !irq_b_o)
		else $error("irq not asserted on boot done");
	a_wake_restart: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$fell(st_reg.sleep) |-> st_reg.restart ##1 (wake_busy && !boot_done))
		else $error("wake did not act as soft reset");
	a_aon_kept: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |=> st_reg.aon_scratch == $past(st_reg.aon_scratch))
		else $error("always-on register lost on reset");
	a_mask_default: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |=> st_reg.mask == IRQ_MASK_RST && !st_reg.mic_dig)
		else $error("register not returned to default");
	a_sleep_dsp_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		$rose(st_reg.sleep) |-> dsp_mem_clear_o && wseq_mem_keep_o)
		else $error("sleep memory handling wrong");
	a_id_read: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(rd_acc && paddr_i == 16'(ADDR_SOFT_RESET)) |-> prdata_o == {16'h0000, DEVICE_ID})
		else $error("identity readback wrong");
	a_rev_read: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(rd_acc && paddr_i == 16'(ADDR_REVISION)) |-> prdata_o == {24'h00_0000, REVISION})
		else $error("revision readback wrong");

	// ------------------------------------------------------------
	// Checks: flags, write blocking and pads
	// ------------------------------------------------------------
	a_boot_flag_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(boot_done && !st_reg.restart) |=> st_reg.boot_seen)
		else $error("boot flag not set after boot");
	a_boot_sts_clr: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |=> !st_reg.sts_boot)
		else $error("boot interrupt status kept over reset");
	a_raw_flag_read: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(rd_acc && paddr_i == ADDR_RAW_STS5_HI)
		|-> (prdata_o[BOOT_DONE_BIT] == st_reg.boot_seen && prdata_o[31:16] == 16'h0000))
		else $error("raw status readback wrong");
	a_irq_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(!irq_b_o && !wr_acc && !st_reg.restart) |=> !irq_b_o)
		else $error("interrupt dropped without clear");
	a_status_w1c: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wr_acc && paddr_i == ADDR_RAW_STS5_HI && pstrb_i[1] && pwdata_i[BOOT_DONE_BIT]
		&& st_reg.boot_seen) |=> !st_reg.sts_boot)
		else $error("boot status not cleared by write");
	a_wake_sts_set: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(st_reg.sleep && st_reg.wake_s2 && !st_reg.wake_d) |=> (st_reg.sts_wake && !st_reg.sleep))
		else $error("wake event not taken");
	a_wake_wait_run: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.wake_start |=> wake_busy)
		else $error("wake wait not started");
	a_sleep_core_off: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.sleep |-> !core_rst_b_o)
		else $error("core not held while asleep");
	a_core_rst_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |-> !core_rst_b_o)
		else $error("core not reset during restart");
	a_busy_mask_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wr_acc && boot_busy && !st_reg.restart) |=> ($stable(st_reg.mask) && $stable(st_reg.mic_dig)))
		else $error("control write taken while booting");
	a_busy_scratch_drop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		(wr_acc && boot_busy) |=> $stable(st_reg.aon_scratch))
		else $error("scratch write taken while booting");
	a_boot_busy_rst: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |=> boot_busy)
		else $error("boot not running after reset");
	a_dsp_clr_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		dsp_mem_clear_o |=> !dsp_mem_clear_o)
		else $error("processor memory clear not a pulse");
	a_sleep_wseq: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.sleep |-> wseq_mem_keep_o)
		else $error("sequencer memory not kept in sleep");
	a_mic_cleared: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
		st_reg.restart |=> !mic_digital_en_o)
		else $error("mic pins not analogue after reset");
	a_pad_pull_down: assert property (@(posedge ref_clk_i)
		gpio_pull_o == PULL_DOWN && regulator_enable_pin_pull_o == PULL_DOWN
		&& test_port_pull_o == PULL_DOWN)
		else $error("pad pull-down default wrong");
	a_reset_pin_up: assert property (@(posedge ref_clk_i)
		hw_reset_pin_pull_o == PULL_UP)
		else $error("reset pin pull-up default wrong");
endmodule // rbi_top
`default_nettype wire

// *** verif/rbi_host_model.sv ***
// Host processor model: APB master that waits for boot, writes init values, waits after wake
`default_nettype none
module rbi_host_model
	import rbi_pkg::*;
#(
	parameter int unsigned WAKE_CYC = 20
) (
	input  wire logic        ref_clk_i,
	input  wire logic        pready_i,
	input  wire logic [31:0] prdata_i,
	input  wire logic        pslverr_i,
	output var logic         psel_o,
	output var logic         penable_o,
	output var logic         pwrite_o,
	output var logic [15:0]  paddr_o,
	output var logic [31:0]  pwdata_o
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] INIT_IDX [9] = '{16'h0019, 16'h0081, 16'h02D4, 16'h035E,
		16'h0443, 16'h04B0, 16'h051B, 16'h055B, 16'h059B};
	localparam logic [15:0] INIT_VAL [9] = '{16'h0001, 16'hE022, 16'h0000, 16'h000C,
		16'hDC1A, 16'h0066, 16'h0001, 16'h0001, 16'h0001};

	initial begin
		psel_o    = 1'b0;
		penable_o = 1'b0;
		pwrite_o  = 1'b0;
		paddr_o   = 16'h0000;
		pwdata_o  = 32'h0000_0000;
	end

	// ------------------------------------------------------------
	// One APB transfer, held until pready is seen high
	// ------------------------------------------------------------
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge ref_clk_i);
		psel_o    <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o  <= w;
		paddr_o   <= a;
		pwdata_o  <= d;
		@(posedge ref_clk_i);
		penable_o <= 1'b1;
		do @(posedge ref_clk_i); while (pready_i !== 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o    <= 1'b0;
		penable_o <= 1'b0;
	endtask

	// Poll the boot flag before any write
	task automatic wait_boot(output logic ok);
		logic [31:0] r;
		logic        e;
		ok = 1'b0;
		for (int i = 0; i < 100 && !ok; i++) begin
			xfer(1'b0, ADDR_RAW_STS5_HI, 32'h0000_0000, r, e);
			ok = (r[BOOT_DONE_BIT] === 1'b1);
		end
	endtask

	task automatic init_seq(output logic [8:0] errs);
		logic [31:0] r;
		for (int i = 0; i < 9; i++) begin
			xfer(1'b1, {INIT_IDX[i][13:0], 2'b00}, {16'h0000, INIT_VAL[i]}, r, errs[i]);
		end
	endtask

	task automatic wait_wake();
		repeat (WAKE_CYC + 4) @(posedge ref_clk_i);
	endtask
endmodule // rbi_host_model
`default_nettype wire

// *** verif/rbi_top_tb_top.sv ***
// Testbench for the reset, boot and identity block
`default_nettype none
module rbi_top_tb_top
	import rbi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [15:0] DEV_ID = 16'h3C96;	// Value is arbitrary
	localparam logic [7:0]  REV    = 8'h2B;	// Value is arbitrary

	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, wake_pin, irq_b;
	logic        core_rst_b, dsp_clr, wseq_keep, sleep, wr_blk, mic_en, ok;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0]  gpio_pull, reg_pull, test_pull, hwr_pull;
	logic [8:0]  errs;
	int          n_errors, num_checks, n_clr, cyc;

	rbi_top #(.DEVICE_ID(DEV_ID), .REVISION(REV), .BOOT_LEN(16), .WAKE_LEN(20)) dut (
		.ref_clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
		.pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .wake_pin_i(wake_pin),
		.irq_b_o(irq_b), .core_rst_b_o(core_rst_b), .dsp_mem_clear_o(dsp_clr),
		.wseq_mem_keep_o(wseq_keep), .sleep_o(sleep), .write_blocked_o(wr_blk),
		.mic_digital_en_o(mic_en), .gpio_pull_o(gpio_pull),
		.regulator_enable_pin_pull_o(reg_pull), .test_port_pull_o(test_pull),
		.hw_reset_pin_pull_o(hwr_pull));

	rbi_host_model #(.WAKE_CYC(20)) host (
		.ref_clk_i(clk), .pready_i(pready), .prdata_i(prdata), .pslverr_i(pslverr),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
		.pwdata_o(pwdata));

	// ------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------
	always #10 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (dsp_clr === 1'b1) n_clr++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		logic e;
		host.xfer(1'b0, a, 32'h0000_0000, d, e);
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        e;
		host.xfer(1'b1, a, d, x, e);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		wake_pin = 1'b0;
		n_errors = 0;
		num_checks = 0;
		n_clr = 0;
		cyc = 0;
		settle(4);
		chk("irq_in_reset", irq_b, 1'b1);
		chk("core_in_reset", core_rst_b, 1'b0);
		chk("mic_digital", mic_en, 1'b0);
		chk("gpio_pull", gpio_pull, PULL_DOWN);
		chk("ldo_pull", reg_pull, PULL_DOWN);
		chk("test_pull", test_pull, PULL_DOWN);
		chk("reset_pull", hwr_pull, PULL_UP);
		chk("wseq_keep", wseq_keep, 1'b1);
		@(posedge clk);
		rst_b <= 1'b1;
		rd(ADDR_RAW_STS5_HI, r);
		chk("boot_busy", r[BOOT_DONE_BIT], 1'b0);
		host.wait_boot(ok);
		chk("boot_done", ok, 1'b1);
		settle(2);
		chk("irq_boot", irq_b, 1'b0);
		rd(ADDR_SOFT_RESET, r);
		chk("device_id", r, {16'h0000, DEV_ID});
		wr(ADDR_REVISION, 32'hFFFF_FFFF);
		rd(ADDR_REVISION, r);
		chk("revision", r, {24'h00_0000, REV});
		host.init_seq(errs);
		chk("init_unmapped", errs, 9'h1F0);
		wr(ADDR_IRQ_MASK5, 32'h0000_0100);
		settle(2);
		chk("irq_masked", irq_b, 1'b1);
		wr(ADDR_IRQ_MASK5, 32'h0000_0000);
		settle(2);
		chk("irq_unmasked", irq_b, 1'b0);
		wr(ADDR_RAW_STS5_HI, 32'h0000_0100);
		settle(2);
		chk("irq_cleared", irq_b, 1'b1);
		rd(ADDR_RAW_STS5_HI, r);
		chk("flag_held", r[BOOT_DONE_BIT], 1'b1);
		wr(ADDR_RETAIN_STS, 32'h0000_0001);
		wr(ADDR_AON_SCRATCH, 32'h0000_5AA5);
		wr(ADDR_IRQ_MASK5, 32'h0000_0100);
		#1 chk("mic_set", mic_en, 1'b1);
		wr(ADDR_SOFT_RESET, 32'h0000_0000);
		#1 chk("soft_reset", core_rst_b, 1'b0);
		rd(ADDR_RAW_STS5_HI, r);
		chk("boot_cleared", r[BOOT_DONE_BIT], 1'b0);
		// Refused: boot still busy
		wr(ADDR_IRQ_MASK5, 32'h0000_0100);
		host.wait_boot(ok);
		chk("reboot", ok, 1'b1);
		rd(ADDR_IRQ_MASK5, r);
		chk("mask_default", r, 32'h0000_0000);
		rd(ADDR_AON_SCRATCH, r);
		chk("scratch_soft", r, 32'h0000_5AA5);
		chk("mic_reset", mic_en, 1'b0);
		chk("irq_reboot", irq_b, 1'b0);
		wr(ADDR_IRQ_MASK5, 32'h0000_0100);
		wr(ADDR_SLEEP_CTRL, 32'h0000_0001);
		settle(2);
		chk("asleep", sleep, 1'b1);
		chk("core_asleep", core_rst_b, 1'b0);
		chk("dsp_clear", n_clr, 1);
		chk("wseq_asleep", wseq_keep, 1'b1);
		@(posedge clk);
		wake_pin <= 1'b1;
		settle(6);
		chk("wake_blocked", wr_blk, 1'b1);
		host.wait_wake();
		wake_pin <= 1'b0;
		#1 chk("wake_open", wr_blk, 1'b0);
		rd(ADDR_AON_SCRATCH, r);
		chk("scratch_wake", r, 32'h0000_5AA5);
		rd(ADDR_IRQ_MASK5, r);
		chk("mask_wake", r, 32'h0000_0000);
		rd(ADDR_RAW_STS5_HI, r);
		chk("wake_boot", r[BOOT_DONE_BIT], 1'b1);
		chk("wake_event", r[0], 1'b1);
		host.init_seq(errs);
		chk("init_wake", errs, 9'h1F0);
		print_verdict();
	end
endmodule // rbi_top_tb_top
`default_nettype wire
